// file: shared/opc_pkg.sv
// Purpose: Constants and carrier types for the opamp control register bank.
// Assumes: Byte-wide registers, one per aligned 32-bit AHB-Lite word.
// Notes:   Printed offsets are register indexes; byte address = index * 4.
`default_nettype none
package opc_pkg;
    // Number of amplifier slots in the larger variant.
    localparam int unsigned OPC_AMP_MAX = 3;
    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] OPC_IDX_AMP0_A = 8'hc0;
    localparam logic [7:0] OPC_IDX_AMP0_B = 8'hc1;
    localparam logic [7:0] OPC_IDX_AMP1_A = 8'hc2;
    localparam logic [7:0] OPC_IDX_AMP1_B = 8'hc3;
    localparam logic [7:0] OPC_IDX_AMP2_A = 8'hc4;
    localparam logic [7:0] OPC_IDX_AMP2_B = 8'hc5;
    localparam logic [7:0] OPC_IDX_STATUS = 8'hcd;
    localparam logic [7:0] OPC_IDX_SWITCH = 8'hcf;
    // Shift from index to byte address.
    localparam int unsigned OPC_ADDR_SHIFT = 2;
    // Storage slots: six amplifier bytes, then the switch byte.
    localparam int unsigned OPC_SLOTS = 7;
    localparam logic [2:0] OPC_SLOT_SWITCH = 3'h6;
    localparam logic [7:0] OPC_RESET_VALUE = 8'h00;
    // Control byte A field positions.
    localparam int unsigned OPC_A_INV_LSB = 6;
    localparam int unsigned OPC_A_NONINV_LSB = 4;
    localparam int unsigned OPC_A_POWER_LSB = 2;
    localparam int unsigned OPC_A_ROUTE_EXT_BIT = 1;
    localparam int unsigned OPC_A_ROUTE_INT_BIT = 0;
    // Control byte B field positions.
    localparam int unsigned OPC_B_TAP_LSB = 5;
    localparam int unsigned OPC_B_FUNC_LSB = 2;
    localparam int unsigned OPC_B_CAL_BIT = 1;
    localparam int unsigned OPC_B_RANGE_BIT = 0;
    // Implemented-bit masks per variant; other bits are reserved.
    localparam logic [7:0] OPC_MASK3_A = 8'hff;
    localparam logic [7:0] OPC_MASK3_B = 8'hfd;
    localparam logic [7:0] OPC_MASK2_A = 8'hfc;
    localparam logic [7:0] OPC_MASK2_B = 8'h1e;
    localparam logic [7:0] OPC_MASK_SWITCH = 8'hff;
    // Switch byte field positions.
    localparam int unsigned OPC_SW_FORCE0_LSB = 0;
    localparam int unsigned OPC_SW_GND0_BIT = 2;
    localparam int unsigned OPC_SW_SHUNT0_BIT = 3;
    localparam int unsigned OPC_SW_FORCE1_LSB = 4;
    localparam int unsigned OPC_SW_GND1_BIT = 6;
    localparam int unsigned OPC_SW_SHUNT1_BIT = 7;
    // Codes.
    localparam logic [1:0] OPC_POWER_OFF = 2'h0;
    localparam logic [1:0] OPC_NONINV_EXT2 = 2'h1;
    localparam logic [1:0] OPC_NONINV_DAC = 2'h2;
    localparam logic [2:0] OPC_FUNC_GENERAL = 3'h0;
    localparam logic [2:0] OPC_FUNC_UNITY = 3'h1;
    localparam logic [2:0] OPC_FUNC_INVERTING = 3'h6;
    localparam logic [1:0] OPC_FORCE_FIRST = 2'h1;
    localparam logic [1:0] OPC_FORCE_SECOND = 2'h2;
    localparam logic [1:0] OPC_FORCED_INV_FIRST = 2'h0;
    localparam logic [1:0] OPC_FORCED_INV_SECOND = 2'h1;

    // Effective settings of one amplifier, as seen by the analog macro.
    typedef struct packed {
        logic       powered;
        logic [1:0] power_level_select;
        logic [1:0] noninverting_input_select;
        logic [1:0] inverting_input_select;
        logic [2:0] function_select;
        logic [2:0] feedback_tap_select;
        logic       output_route_converter_ext;
        logic       output_route_converter_int;
        logic       input_range_limit;
        logic       calibrate;
        logic       forced;
        logic       func_reserved;
    } opc_amp_type;

    // Analog switch controls.
    typedef struct packed {
        logic shunt1;
        logic ground1;
        logic shunt0;
        logic ground0;
    } opc_switch_type;
endpackage : opc_pkg
`default_nettype wire

// file: verilog/opc_regs.sv
// Purpose: AHB-Lite register bank steering up to three on-chip opamps.
// Assumes: Single whole-word transfers; only the low byte lane is used.
// Notes:   Zero wait states; reads of the register being written in the
//          previous beat return the new value.
`timescale 1ns/1ps
`default_nettype none
module opc_regs
    import opc_pkg::*;
#(
    parameter bit THREE_AMP = 1'b1
) (
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST_B,
    input  wire logic                          HSEL,
    input  wire logic [31:0]                   HADDR,
    input  wire logic [1:0]                    HTRANS,
    input  wire logic                          HWRITE,
    input  wire logic [2:0]                    HSIZE,
    input  wire logic [31:0]                   HWDATA,
    input  wire logic                          HREADY,
    output logic                               HREADYOUT,
    output logic                               HRESP,
    output logic [31:0]                        HRDATA,
    output opc_amp_type [OPC_AMP_MAX-1:0]      AMP_CTRL,
    output opc_switch_type                     SWITCH_CTRL
);

    // Map a byte address to a storage slot; valid flag says it is mapped.
    function automatic logic [3:0] addr_to_slot(input logic [31:0] addr);
        logic [29:0] idx;
        logic [3:0]  res;
        idx = addr[31:OPC_ADDR_SHIFT];
        res = 4'h0;
        if (addr[OPC_ADDR_SHIFT-1:0] == 2'h0) begin
            if (idx == {22'h0, OPC_IDX_AMP0_A}) res = 4'h8;
            if (idx == {22'h0, OPC_IDX_AMP0_B}) res = 4'h9;
            if (idx == {22'h0, OPC_IDX_AMP1_A}) res = 4'ha;
            if (idx == {22'h0, OPC_IDX_AMP1_B}) res = 4'hb;
            if (THREE_AMP && idx == {22'h0, OPC_IDX_AMP2_A}) res = 4'hc;
            if (THREE_AMP && idx == {22'h0, OPC_IDX_AMP2_B}) res = 4'hd;
            if (!THREE_AMP && idx == {22'h0, OPC_IDX_SWITCH}) res = 4'he;
        end
        return res;
    endfunction

    // Implemented bits of a slot in the configured variant.
    function automatic logic [7:0] slot_mask(input logic [2:0] slot);
        logic [7:0] m;
        m = 8'h00;
        if (slot == OPC_SLOT_SWITCH) begin
            m = THREE_AMP ? 8'h00 : OPC_MASK_SWITCH;
        end else if (slot[0] == 1'b0) begin
            m = THREE_AMP ? OPC_MASK3_A : OPC_MASK2_A;
        end else begin
            m = THREE_AMP ? OPC_MASK3_B : OPC_MASK2_B;
        end
        return m;
    endfunction

    // Function codes that software is not to select in this variant.
    function automatic logic func_is_reserved(input logic [2:0] code);
        logic r;
        r = 1'b0;
        if (THREE_AMP) begin
            r = (code == 3'h5) || (code == 3'h7);
        end else begin
            r = (code != OPC_FUNC_GENERAL) && (code != OPC_FUNC_UNITY)
                && (code != OPC_FUNC_INVERTING);
        end
        return r;
    endfunction

    // Bus pipeline: address phase captured, used in the data phase.
    logic       wr_pend_q;
    logic       wr_pend_d;
    logic [2:0] wr_slot_q;
    logic [2:0] wr_slot_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Register storage and its next value.
    logic [7:0] regs_q [0:OPC_SLOTS-1];
    logic [7:0] regs_d [0:OPC_SLOTS-1];

    // Effective outputs.
    opc_amp_type [OPC_AMP_MAX-1:0] amp_q;
    opc_amp_type [OPC_AMP_MAX-1:0] amp_d;
    opc_switch_type                sw_q;
    opc_switch_type                sw_d;

    // Address-phase decode.
    wire        phase_take = HSEL && HTRANS[1] && HREADY;
    wire [3:0]  dec        = addr_to_slot(HADDR);
    wire        dec_hit    = dec[3];
    wire [2:0]  dec_slot   = dec[2:0];
    wire        is_status  = (HADDR[31:OPC_ADDR_SHIFT]
                              == {22'h0, OPC_IDX_STATUS})
                             && (HADDR[OPC_ADDR_SHIFT-1:0] == 2'h0);

    // Zero wait states and always OKAY.
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_q;
    assign AMP_CTRL    = amp_q;
    assign SWITCH_CTRL = sw_q;

    // Only mapped writes become pending; unmapped ones vanish.
    assign wr_pend_d = phase_take && HWRITE && dec_hit;
    assign wr_slot_d = dec_slot;

    // Next register values: the data-phase write lands in its slot.
    // Reserved bits dropped
    always_comb begin
        for (int i = 0; i < OPC_SLOTS; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_pend_q) begin
            regs_d[wr_slot_q] = HWDATA[7:0] & slot_mask(wr_slot_q);
        end
    end

    // Stored bytes as seen from the next state, for bypassed reads.
    wire [7:0] status_byte;
    wire [7:0] rd_byte = dec_hit ? regs_d[dec_slot]
                        : (is_status ? status_byte : 8'h00);

    // Read data is sampled at the address phase from the next state.
    // Read back value
    assign rdata_d = (phase_take && !HWRITE) ? {24'h0, rd_byte} : 32'h0;

    // Own status byte: power, forcing and reserved-code flags.
    assign status_byte = {amp_q[2].func_reserved,
                          amp_q[1].func_reserved,
                          amp_q[0].func_reserved,
                          amp_q[1].forced,
                          amp_q[0].forced,
                          amp_q[2].powered,
                          amp_q[1].powered,
                          amp_q[0].powered};

    // Switch byte fields for each forced amplifier.
    wire [7:0] sw_byte = regs_q[OPC_SLOT_SWITCH];
    wire [1:0] force0  = sw_byte[OPC_SW_FORCE0_LSB +: 2];
    wire [1:0] force1  = sw_byte[OPC_SW_FORCE1_LSB +: 2];

    // Build each amplifier's effective setting from its two bytes.
    always_comb begin
        logic [7:0] ba;
        logic [7:0] bb;
        logic [1:0] frc;
        ba  = 8'h00;
        bb  = 8'h00;
        frc = 2'h0;
        for (int a = 0; a < OPC_AMP_MAX; a++) begin
            ba  = regs_q[2*a];
            bb  = regs_q[2*a+1];
            frc = (a == 0) ? force0 : ((a == 1) ? force1 : 2'h0);
            if (THREE_AMP || a == 0) begin
                frc = THREE_AMP ? 2'h0 : frc;
            end
            if (!THREE_AMP && a == 2) begin
                ba = 8'h00;
                bb = 8'h00;
            end
            amp_d[a].power_level_select = ba[OPC_A_POWER_LSB +: 2];
            amp_d[a].powered = (ba[OPC_A_POWER_LSB +: 2] != OPC_POWER_OFF);
            amp_d[a].noninverting_input_select = ba[OPC_A_NONINV_LSB +: 2];
            amp_d[a].inverting_input_select = ba[OPC_A_INV_LSB +: 2];
            amp_d[a].function_select = bb[OPC_B_FUNC_LSB +: 3];
            amp_d[a].feedback_tap_select = THREE_AMP
                ? bb[OPC_B_TAP_LSB +: 3] : 3'h0;
            amp_d[a].output_route_converter_ext =
                THREE_AMP && ba[OPC_A_ROUTE_EXT_BIT];
            amp_d[a].output_route_converter_int =
                THREE_AMP && ba[OPC_A_ROUTE_INT_BIT];
            amp_d[a].input_range_limit = THREE_AMP && bb[OPC_B_RANGE_BIT];
            amp_d[a].calibrate = !THREE_AMP && bb[OPC_B_CAL_BIT];
            amp_d[a].forced = 1'b0;
            if (frc == OPC_FORCE_FIRST) begin
                amp_d[a].inverting_input_select = OPC_FORCED_INV_FIRST;
                amp_d[a].function_select = OPC_FUNC_INVERTING;
                amp_d[a].forced = 1'b1;
            end else if (frc == OPC_FORCE_SECOND) begin
                amp_d[a].inverting_input_select = OPC_FORCED_INV_SECOND;
                amp_d[a].function_select = OPC_FUNC_INVERTING;
                amp_d[a].forced = 1'b1;
            end
            amp_d[a].func_reserved =
                func_is_reserved(amp_d[a].function_select);
        end
    end

    // Switch controls only exist in the two-amplifier variant.
    // Switch register outputs
    assign sw_d.shunt1  = !THREE_AMP && sw_byte[OPC_SW_SHUNT1_BIT];
    assign sw_d.ground1 = !THREE_AMP && sw_byte[OPC_SW_GND1_BIT];
    assign sw_d.shunt0  = !THREE_AMP && sw_byte[OPC_SW_SHUNT0_BIT];
    assign sw_d.ground0 = !THREE_AMP && sw_byte[OPC_SW_GND0_BIT];

    // Bus pipeline registers.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_q <= 1'b0;
            wr_slot_q <= 3'h0;
            rdata_q   <= 32'h0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_slot_q <= wr_slot_d;
            rdata_q   <= rdata_d;
        end
    end

    // Register storage, cleared by the system reset.
    // Cleared storage
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < OPC_SLOTS; i++) begin
                regs_q[i] <= OPC_RESET_VALUE;
            end
        end else begin
            for (int i = 0; i < OPC_SLOTS; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // Effective settings registered towards the analog macro.
    // Amplifier and switch outputs
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            amp_q <= '0;
            sw_q  <= '0;
        end else begin
            amp_q <= amp_d;
            sw_q  <= sw_d;
        end
    end

endmodule // opc_regs
`default_nettype wire

// file: testbench/opc_regs_monitor.sv
// Purpose: Port assertions for the opamp control register bank.
// Assumes: Zero wait states; outputs follow a write one edge later.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
module opc_regs_monitor
    import opc_pkg::*;
#(
    parameter bit THREE_AMP = 1'b1
) (
    input wire logic                          CLK_SYS,
    input wire logic                          RST_B,
    input wire logic                          HSEL,
    input wire logic [31:0]                   HADDR,
    input wire logic [1:0]                    HTRANS,
    input wire logic                          HWRITE,
    input wire logic [2:0]                    HSIZE,
    input wire logic [31:0]                   HWDATA,
    input wire logic                          HREADY,
    input wire logic                          HREADYOUT,
    input wire logic                          HRESP,
    input wire logic [31:0]                   HRDATA,
    input wire opc_amp_type [OPC_AMP_MAX-1:0] AMP_CTRL,
    input wire opc_switch_type                SWITCH_CTRL
);
    logic        ph_q;
    logic        wr_q;
    logic [11:0] addr_q;
    wire logic   wr_dp = ph_q && wr_q;
    wire logic   rd_dp = ph_q && !wr_q;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    // Remembers the address phase so the data phase can be judged.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ph_q   <= 1'b0;
            wr_q   <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            ph_q   <= HSEL && HTRANS[1] && HREADY;
            wr_q   <= HWRITE;
            addr_q <= HADDR[11:0];
        end
    end

    // Checks tie outputs to the transfer that caused them; reset, reserved-flag and upper-byte checks stand alone.
    reset_clear_a: assert property (
        $rose(RST_B) |-> AMP_CTRL == '0 && SWITCH_CTRL == '0)
        else $error("Outputs not clear after reset.");
    unmapped_read_a: assert property (
        rd_dp && addr_q == 12'h318 |-> HRDATA == 32'h0)
        else $error("Unmapped read not zero.");
    power_write_a: assert property (
        wr_dp && addr_q == 12'h300 |-> ##2 AMP_CTRL[0].power_level_select
        == $past(HWDATA[3:2], 2) && AMP_CTRL[0].powered
        == ($past(HWDATA[3:2], 2) != 2'h0))
        else $error("Power level not applied.");
    func_write_a: assert property (
        THREE_AMP && wr_dp && addr_q == 12'h304
        |-> ##2 AMP_CTRL[0].function_select == $past(HWDATA[4:2], 2))
        else $error("Function not applied.");
    tap_write_a: assert property (
        THREE_AMP && wr_dp && addr_q == 12'h314
        |-> ##2 AMP_CTRL[2].feedback_tap_select == $past(HWDATA[7:5], 2))
        else $error("Feedback tap not applied.");
    noninv_write_a: assert property (
        wr_dp && addr_q == 12'h308 |-> ##2
        AMP_CTRL[1].noninverting_input_select == $past(HWDATA[5:4], 2))
        else $error("Input select not applied.");
    reserved_flag_a: assert property (
        !THREE_AMP |-> AMP_CTRL[0].func_reserved
        == !(AMP_CTRL[0].function_select inside {3'h0, 3'h1, 3'h6}))
        else $error("Reserved function not flagged.");
    force_first_a: assert property (
        !THREE_AMP && wr_dp && addr_q == 12'h33c && HWDATA[1:0] == 2'h1
        |-> ##2 AMP_CTRL[0].forced && AMP_CTRL[0].function_select == 3'h6
        && AMP_CTRL[0].inverting_input_select == 2'h0)
        else $error("First forcing code not applied.");
    force_second_a: assert property (
        !THREE_AMP && wr_dp && addr_q == 12'h33c && HWDATA[5:4] == 2'h2
        |-> ##2 AMP_CTRL[1].function_select == 3'h6
        && AMP_CTRL[1].inverting_input_select == 2'h1)
        else $error("Second forcing code not applied.");
    reserved_read_a: assert property (
        rd_dp && !THREE_AMP && addr_q == 12'h300 |-> HRDATA[1:0] == 2'h0)
        else $error("Reserved bits read set.");
    high_bytes_a: assert property (HRDATA[31:8] == 24'h0)
        else $error("Upper read bytes set.");

    // Main scenarios seen.
    cover property (wr_dp && addr_q == 12'h33c);
    cover property (AMP_CTRL[0].forced);
    cover property (rd_dp && HRDATA != 32'h0);
endmodule // opc_regs_monitor
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Self-checking bench for both variants of the register bank.
// Assumes: Zero wait states; one AHB-Lite master drives both banks.
// Notes:   Upper write-data bytes carry junk that must be ignored.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import opc_pkg::*;
;
    logic                          clk_sys = 1'b0;
    logic                          rst_b   = 1'b0;
    logic                          hsel    = 1'b0;
    logic [31:0]                   haddr   = 32'h0;
    logic [1:0]                    htrans  = 2'h0;
    logic                          hwrite  = 1'b0;
    logic [31:0]                   hwdata  = 32'h0;
    logic                          hready;
    logic [31:0]                   hrdata3, hrdata2, rd3, rd2;
    opc_amp_type [OPC_AMP_MAX-1:0] amp3, amp2;
    opc_switch_type                sw3, sw2;
    int                            miscompares = 0;
    int                            check_count = 0;
    logic [31:0] addr_t [8] = '{32'h300, 32'h304, 32'h308, 32'h30c,
                                32'h310, 32'h314, 32'h33c, 32'h318};
    logic [7:0]  exp3_t [8] = '{8'hff, 8'hfd, 8'hff, 8'hfd,
                                8'hff, 8'hfd, 8'h00, 8'h00};
    logic [7:0]  exp2_t [8] = '{8'hfc, 8'h1e, 8'hfc, 8'h1e,
                                8'h00, 8'h00, 8'hff, 8'h00};

    // Three-amplifier bank and two-amplifier bank on one bus.
    opc_regs #(.THREE_AMP(1'b1)) u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
        .HRESP(), .HRDATA(hrdata3), .AMP_CTRL(amp3), .SWITCH_CTRL(sw3));
    opc_regs #(.THREE_AMP(1'b0)) u_dut2 (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(),
        .HRESP(), .HRDATA(hrdata2), .AMP_CTRL(amp2), .SWITCH_CTRL(sw2));

    always #5 clk_sys = ~clk_sys;

    // Compares one result and counts it.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Waits for ready at a rising edge; read data is taken at that edge.
    task automatic wait_rdy();
        int   n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        while (!rdy && n < 16) begin
            @(posedge clk_sys);
            rd3 = hrdata3;
            rd2 = hrdata2;
            rdy = hready;
            n++;
        end
        if (!rdy) begin
            miscompares++;
            print_verdict();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'ha5a5a5, d};
        wait_rdy();
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask

    // Reads both banks and compares with the expected bytes.
    task automatic rd(input logic [31:0] a, input logic [7:0] e3,
                      input logic [7:0] e2);
        bus(a, 1'b0, 8'h00);
        check(rd3, {24'h0, e3});
        check(rd2, {24'h0, e2});
    endtask

    // Lets the output update one edge after the write lands.
    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    // Holds reset for six cycles, then checks that the registers read zero and amp2[0] is clear.
    task automatic reset_and_check();
        rst_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rd(addr_t[i], 8'h00, 8'h00);
        end
        check(32'(amp2[0]), 32'h0);
    endtask

    // Main sequence.
    initial begin
        reset_and_check();
        for (int i = 0; i < 8; i++) begin
            wr(addr_t[i], 8'hff);
            rd(addr_t[i], exp3_t[i], exp2_t[i]);
        end
        for (int p = 0; p < 4; p++) begin
            wr(32'h300, 8'(p << 2) | 8'h10);
            settle();
            check(32'(amp3[0].power_level_select), 32'(p));
            check(32'(amp3[0].powered), 32'(p != 0));
            check(32'(amp2[0].noninverting_input_select), 32'h1);
        end
        wr(32'h308, 8'h20);
        settle();
        check(32'(amp3[1].noninverting_input_select), 32'h2);
        for (int f = 0; f < 8; f++) begin
            wr(32'h304, 8'((f << 5) | (f << 2)));
            settle();
            check(32'(amp3[0].function_select), 32'(f));
            check(32'(amp3[0].feedback_tap_select), 32'(f));
            check(32'(amp2[0].function_select), 32'(f));
            check(32'(amp2[0].func_reserved), 32'(!(f inside {0, 1, 6})));
        end
        wr(32'h300, 8'hc0);
        wr(32'h308, 8'hc0);
        wr(32'h304, 8'h00);
        wr(32'h30c, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(32'h33c, 8'(c * 8'h55));
            settle();
            for (int k = 0; k < 2; k++) begin
                check(32'(amp2[k].inverting_input_select),
                      (c == 1) ? 32'h0 : (c == 2) ? 32'h1 : 32'h3);
                check(32'(amp2[k].function_select),
                      (c inside {1, 2}) ? 32'h6 : 32'h0);
                check(32'(amp3[k].forced), 32'h0);
            end
            check(32'(sw2), 32'(c * 5));
            rd(32'h304, 8'h00, 8'h00);
            if (c == 1) rd(32'h334, 8'h84, 8'h18);
        end
        reset_and_check();
        print_verdict();
    end
endmodule // testbench

bind opc_regs opc_regs_monitor #(.THREE_AMP(THREE_AMP)) u_mon (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .AMP_CTRL(AMP_CTRL), .SWITCH_CTRL(SWITCH_CTRL));
`default_nettype wire
